// ### rtl/phy_led_cfg.sv
// third indicator, stretch and vendor configuration registers
// assumes a serial management engine supplies word writes and reads
// and that status inputs already sit on clk_i; straps are pins

// Notes on behaviour
// - field 7:4 picks third LED's source
// - codes 8..b force on/off or blink
// - c/d: link solid, rx/activity toggles
// - activity blinks whether link up or down
// - code e: full duplex solid, collision toggles
// - codes 6 and f show nothing
// - stretch 30/60/100 ms, 11 reserved
// - stretch enable bit gates stretching
// - combined codes always stretched
// - symbol select routes symbol error to rxer
// - drive bit raises MII pad drive
// - low power bit forces zero-differential output
// - slew field caught from straps once they agree after reset release
module phy_led_cfg
    import phy_cfg_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter int S30 = STRETCH30_CYC,
    parameter int S60 = STRETCH60_CYC,
    parameter int S100 = STRETCH100_CYC,
    parameter int BF = BLINK_FAST_CYC,
    parameter int BS = BLINK_SLOW_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    input wire phy_cfg_pkg::phy_status_t status_i,
    input wire logic rx_err_i,
    input wire logic sym_err_i,
    input wire logic [1:0] slew_strap_pins_i,
    output logic third_indicator_source_o,
    output logic mii_rxer_o,
    output logic mii_drive_hi_o,
    output logic tx_low_power_o,
    output logic [1:0] rise_time_sel_o
);
    import phy_cfg_pkg::*;

    // ------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------
    logic [1:0] s1_ff, s2_ff, s3_ff;
    always_ff @(posedge clk_i) begin
        s1_ff <= slew_strap_pins_i;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] src_ff, nxt_src;
    logic [1:0] per_ff, nxt_per;
    logic str_en_ff, nxt_str_en;
    logic drive_ff, nxt_drive;
    logic symerr_ff, nxt_symerr;
    logic lowpwr_ff, nxt_lowpwr;
    logic [1:0] slew_ff, nxt_slew;
    logic rst_d_ff;
    logic [15:0] rd_ff, nxt_rd;

    always_comb begin
        nxt_src = src_ff;
        nxt_per = per_ff;
        nxt_str_en = str_en_ff;
        nxt_drive = drive_ff;
        nxt_symerr = symerr_ff;
        nxt_lowpwr = lowpwr_ff;
        nxt_slew = slew_ff;
        // strap load while agreeing straps follow reset release
        if (!rst_d_ff && (s2_ff == s3_ff)) begin
            nxt_slew = s3_ff;
        end
        if (wr_en_i) begin
            unique case (addr_i)
                LED_CFG_ADDR: begin
                    nxt_src = wdata_i[SRC_LSB +: 4];
                    nxt_per = wdata_i[PER_LSB +: 2];
                    nxt_str_en = wdata_i[STR_EN_BIT];
                end
                DIG_CFG_ADDR: begin
                    nxt_drive = wdata_i[DRIVE_BIT];
                    nxt_symerr = wdata_i[SYMERR_BIT];
                end
                TX_CTL_ADDR: begin
                    nxt_lowpwr = wdata_i[LOWPWR_BIT];
                    nxt_slew = wdata_i[SLEW_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
        // read mux: unmapped and reserved bits read zero
        nxt_rd = 16'h0000;
        unique case (addr_i)
            LED_CFG_ADDR: begin
                nxt_rd[SRC_LSB +: 4] = src_ff;
                nxt_rd[PER_LSB +: 2] = per_ff;
                nxt_rd[STR_EN_BIT] = str_en_ff;
            end
            DIG_CFG_ADDR: begin
                nxt_rd[DRIVE_BIT] = drive_ff;
                nxt_rd[SYMERR_BIT] = symerr_ff;
            end
            TX_CTL_ADDR: begin
                nxt_rd[LOWPWR_BIT] = lowpwr_ff;
                nxt_rd[SLEW_LSB +: 2] = slew_ff;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            src_ff <= SRC_RESET;
            per_ff <= PER_RESET;
            str_en_ff <= STR_EN_RESET;
            drive_ff <= 1'b0;
            symerr_ff <= 1'b0;
            lowpwr_ff <= 1'b0;
            slew_ff <= 2'h0;
            rst_d_ff <= 1'b0;
            rd_ff <= 16'h0000;
        end else begin
            src_ff <= nxt_src;
            per_ff <= nxt_per;
            str_en_ff <= nxt_str_en;
            drive_ff <= nxt_drive;
            symerr_ff <= nxt_symerr;
            lowpwr_ff <= nxt_lowpwr;
            slew_ff <= nxt_slew;
            rst_d_ff <= rst_d_ff | (s2_ff == s3_ff);
            rd_ff <= nxt_rd;
        end
    end

    assign rdata_o = rd_ff;
    assign mii_drive_hi_o = drive_ff;
    assign tx_low_power_o = lowpwr_ff;
    assign rise_time_sel_o = slew_ff;

    // ------------------------------------------------------------
    // rx error routing
    // ------------------------------------------------------------
    logic rxer_ff;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rxer_ff <= 1'b0;
        end else begin
            rxer_ff <= symerr_ff ? sym_err_i : rx_err_i;
        end
    end
    assign mii_rxer_o = rxer_ff;

    // ------------------------------------------------------------
    // blink timebase
    // ------------------------------------------------------------
    logic [CNT_W-1:0] fast_ff, nxt_fast, slow_ff, nxt_slow;
    logic fast_ph_ff, nxt_fast_ph, slow_ph_ff, nxt_slow_ph;
    always_comb begin
        nxt_fast = fast_ff + 1'b1;
        nxt_fast_ph = fast_ph_ff;
        if (fast_ff == CNT_W'(BF / 2 - 1)) begin
            nxt_fast = '0;
            nxt_fast_ph = !fast_ph_ff;
        end
        nxt_slow = slow_ff + 1'b1;
        nxt_slow_ph = slow_ph_ff;
        if (slow_ff == CNT_W'(BS / 2 - 1)) begin
            nxt_slow = '0;
            nxt_slow_ph = !slow_ph_ff;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fast_ff <= '0;
            slow_ff <= '0;
            fast_ph_ff <= 1'b0;
            slow_ph_ff <= 1'b0;
        end else begin
            fast_ff <= nxt_fast;
            slow_ff <= nxt_slow;
            fast_ph_ff <= nxt_fast_ph;
            slow_ph_ff <= nxt_slow_ph;
        end
    end

    // ------------------------------------------------------------
    // event stretching and display
    // ------------------------------------------------------------
    logic [CNT_W-1:0] len;
    logic evt, evt_st;
    logic combined, led;
    always_comb begin
        unique case (per_ff)
            2'h0: len = CNT_W'(S30);
            2'h1: len = CNT_W'(S60);
            2'h2: len = CNT_W'(S100);
            default: len = CNT_W'(S30);
        endcase
        unique case (src_ff)
            SRC_TX: evt = status_i.tx_evt;
            SRC_RX, SRC_LINK_RX: evt = status_i.rx_evt;
            SRC_COL, SRC_DUP_COL: evt = status_i.col_evt;
            SRC_ACT, SRC_LINK_ACT: evt = status_i.rx_evt | status_i.tx_evt;
            default: evt = 1'b0;
        endcase
    end
    assign combined = src_ff inside {SRC_LINK_RX, SRC_LINK_ACT, SRC_DUP_COL};

    event_stretch #(.CNT_W(CNT_W)) u_stretch (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .evt_i(evt),
        .len_i(len),
        .out_o(evt_st)
    );

    always_comb begin
        led = 1'b0;
        unique case (src_ff)
            SRC_SPEED: led = status_i.speed_100;
            SRC_LINK: led = status_i.link_up;
            SRC_DUPLEX: led = status_i.full_duplex;
            SRC_TX, SRC_RX, SRC_COL, SRC_ACT:
                led = str_en_ff ? evt_st : evt;
            SRC_ON: led = 1'b1;
            SRC_OFF: led = 1'b0;
            SRC_FAST: led = fast_ph_ff;
            SRC_SLOW: led = slow_ph_ff;
            // primary level, inverted while a stretched event lasts
            SRC_LINK_RX, SRC_LINK_ACT:
                led = status_i.link_up ^ evt_st;
            SRC_DUP_COL: led = status_i.full_duplex ^ evt_st;
            default: led = 1'b0;
        endcase
    end

    logic led_ff;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            led_ff <= 1'b0;
        end else begin
            led_ff <= led;
        end
    end
    assign third_indicator_source_o = led_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_src;
        @(posedge clk_i) $rose(rst_n_i) |-> src_ff == SRC_RESET && str_en_ff;
    endproperty
    a_reset_src: assert property (p_reset_src) else $error("bad reset");

    property p_force_on;
        @(posedge clk_i) disable iff (!rst_n_i)
            src_ff == SRC_ON |=> third_indicator_source_o;
    endproperty
    a_force_on: assert property (p_force_on) else $error("led not on");

    property p_unused;
        @(posedge clk_i) disable iff (!rst_n_i)
            src_ff inside {SRC_UNUSED6, SRC_UNUSED15} |=> !third_indicator_source_o;
    endproperty
    a_unused: assert property (p_unused) else $error("unused lit");

    property p_link_solid;
        @(posedge clk_i) disable iff (!rst_n_i)
            src_ff inside {SRC_LINK_RX, SRC_LINK_ACT} && !evt_st |=>
                third_indicator_source_o == $past(status_i.link_up);
    endproperty
    a_link_solid: assert property (p_link_solid) else $error("link");

    sequence s_comb_evt;
        combined && evt;
    endsequence
    property p_comb_str;
        @(posedge clk_i) disable iff (!rst_n_i)
            s_comb_evt ##1 (src_ff inside {SRC_LINK_RX, SRC_LINK_ACT}) |=>
                third_indicator_source_o != $past(status_i.link_up);
    endproperty
    a_comb_str: assert property (p_comb_str) else $error("comb");

    property p_nostretch;
        @(posedge clk_i) disable iff (!rst_n_i)
            src_ff == SRC_TX && !str_en_ff && !status_i.tx_evt |=> !third_indicator_source_o;
    endproperty
    a_nostretch: assert property (p_nostretch) else $error("stretched");

    property p_rxer;
        @(posedge clk_i) disable iff (!rst_n_i)
            symerr_ff |=> mii_rxer_o == $past(sym_err_i);
    endproperty
    a_rxer: assert property (p_rxer) else $error("rxer source");

    sequence s_wr_dig;
        wr_en_i && addr_i == DIG_CFG_ADDR && wdata_i[DRIVE_BIT];
    endsequence
    property p_drive;
        @(posedge clk_i) disable iff (!rst_n_i) s_wr_dig |=> mii_drive_hi_o;
    endproperty
    a_drive: assert property (p_drive) else $error("drive");

    property p_lowpwr;
        @(posedge clk_i) disable iff (!rst_n_i)
            wr_en_i && addr_i == TX_CTL_ADDR |=>
                tx_low_power_o == $past(wdata_i[LOWPWR_BIT]);
    endproperty
    a_lowpwr: assert property (p_lowpwr) else $error("low power");

    property p_rsv;
        @(posedge clk_i) disable iff (!rst_n_i)
            1'b1 |=> rdata_o[15:8] == 8'h00 || $past(addr_i) != LED_CFG_ADDR;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved nonzero");
endmodule : phy_led_cfg

// ### rtl/phy_cfg_pkg.sv
// package: register offsets, field positions, reset values, timing counts
// assumes a 20 MHz management-side clock and 5-bit register addresses
package phy_cfg_pkg;
    localparam logic [4:0] LED_CFG_ADDR = 5'h14;
    localparam logic [4:0] DIG_CFG_ADDR = 5'h1a;
    localparam logic [4:0] TX_CTL_ADDR = 5'h1e;
    localparam int SRC_LSB = 4;
    localparam int PER_LSB = 2;
    localparam int STR_EN_BIT = 1;
    localparam int DRIVE_BIT = 11;
    localparam int SYMERR_BIT = 9;
    localparam int LOWPWR_BIT = 12;
    localparam int SLEW_LSB = 10;
    localparam logic [3:0] SRC_RESET = 4'h2;
    localparam logic [1:0] PER_RESET = 2'h0;
    localparam logic STR_EN_RESET = 1'b1;
    localparam int CLK_HZ = 20000000;
    localparam int STRETCH30_MS = 30;
    localparam int STRETCH60_MS = 60;
    localparam int STRETCH100_MS = 100;
    localparam int BLINK_FAST_MS = 100;
    localparam int BLINK_SLOW_MS = 500;
    localparam int STRETCH30_CYC = STRETCH30_MS * (CLK_HZ / 1000);
    localparam int STRETCH60_CYC = STRETCH60_MS * (CLK_HZ / 1000);
    localparam int STRETCH100_CYC = STRETCH100_MS * (CLK_HZ / 1000);
    localparam int BLINK_FAST_CYC = BLINK_FAST_MS * (CLK_HZ / 1000);
    localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * (CLK_HZ / 1000);

    typedef enum logic [3:0] {
        SRC_SPEED = 4'h0, SRC_TX = 4'h1, SRC_RX = 4'h2, SRC_COL = 4'h3,
        SRC_LINK = 4'h4, SRC_DUPLEX = 4'h5, SRC_UNUSED6 = 4'h6,
        SRC_ACT = 4'h7, SRC_ON = 4'h8, SRC_OFF = 4'h9, SRC_FAST = 4'ha,
        SRC_SLOW = 4'hb, SRC_LINK_RX = 4'hc, SRC_LINK_ACT = 4'hd,
        SRC_DUP_COL = 4'he, SRC_UNUSED15 = 4'hf
    } led_src_t;

    typedef struct packed {
        logic speed_100;
        logic link_up;
        logic full_duplex;
        logic tx_evt;
        logic rx_evt;
        logic col_evt;
    } phy_status_t;
endpackage : phy_cfg_pkg

// ### rtl/event_stretch.sv
// one stretcher: holds its output for a chosen count after an event
// assumes event input is on the same clock
module event_stretch #(
    parameter int CNT_W = 22
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic evt_i,
    input wire logic [CNT_W-1:0] len_i,
    output logic out_o
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (evt_i) begin
            nxt_cnt = len_i;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign out_o = evt_i || (cnt_ff != '0);
endmodule : event_stretch

// ### sim/phy_status_model.sv
// partner: line-side status events, receive error lines, strap pins
// assumes the bench calls its tasks; changes land at falling edges
module phy_status_model
    import phy_cfg_pkg::*;
(
    input wire logic clk_i,
    output phy_cfg_pkg::phy_status_t status_o,
    output logic rx_err_o,
    output logic sym_err_o,
    output logic [1:0] strap_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] st = 6'h00;
    assign status_o = st;
    initial begin
        rx_err_o = 1'b0;
        sym_err_o = 1'b0;
        strap_o = 2'h2;
    end
    // levels: speed, link, duplex
    task automatic lvl(input logic [2:0] v);
        st[5:3] = v;
    endtask : lvl
    // one-cycle event pulse on bit b
    task automatic evt(input int b);
        @(negedge clk_i);
        st[b] = 1'b1;
        @(negedge clk_i);
        st[b] = 1'b0;
    endtask : evt
    task automatic err(input logic r, input logic s);
        rx_err_o = r;
        sym_err_o = s;
    endtask : err
    task automatic strap(input logic [1:0] v);
        strap_o = v;
    endtask : strap
endmodule : phy_status_model

// ### sim/phy_led_and_vendor_config_regs_bench.sv
// bench: register, indicator and pad control checks of phy_led_cfg
// assumes shortened counts; inputs change at falling edges
module phy_led_and_vendor_config_regs_bench
    import phy_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int S30 = 20;
    localparam int S60 = 40;
    localparam int S100 = 60;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    phy_status_t status;
    logic rx_err;
    logic sym_err;
    logic [1:0] strap;
    logic led;
    logic rxer;
    logic drv;
    logic lowp;
    logic [1:0] rise;
    int fail_count = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    phy_led_cfg #(
        .CNT_W(24),
        .S30(S30),
        .S60(S60),
        .S100(S100),
        .BF(8),
        .BS(32)
    ) dut (
        .clk_i(clk),
        .rst_n_i(rst_n),
        .wr_en_i(wr_en),
        .addr_i(addr),
        .wdata_i(wdata),
        .rdata_o(rdata),
        .status_i(status),
        .rx_err_i(rx_err),
        .sym_err_i(sym_err),
        .slew_strap_pins_i(strap),
        .third_indicator_source_o(led),
        .mii_rxer_o(rxer),
        .mii_drive_hi_o(drv),
        .tx_low_power_o(lowp),
        .rise_time_sel_o(rise)
    );
    phy_status_model m (
        .clk_i(clk),
        .status_o(status),
        .rx_err_o(rx_err),
        .sym_err_o(sym_err),
        .strap_o(strap)
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(rdata, e);
    endtask : rd
    function automatic logic [15:0] cfg(input logic [3:0] c,
        input logic [1:0] p, input logic en);
        return {8'h00, c, p, en, 1'b0};
    endfunction : cfg
    // lit cycles of one event, judged against a window
    task automatic cnt(input int b, input int lo, input int hi);
        int n = 0;
        fork
            m.evt(b);
            repeat (hi + 10) begin
                @(negedge clk);
                if (led === 1'b1) n++;
            end
        join
        check(16'(n >= lo && n <= hi), 16'h0001);
    endtask : cnt
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(LED_CFG_ADDR, 16'h0022);
        rd(DIG_CFG_ADDR, 16'h0000);
        rd(TX_CTL_ADDR, 16'h0800);
        wr(5'h00, 16'hffff);
        wr(LED_CFG_ADDR, 16'hffff);
        wr(DIG_CFG_ADDR, 16'hffff);
        wr(TX_CTL_ADDR, 16'hffff);
        rd(5'h00, 16'h0000);
        rd(LED_CFG_ADDR, 16'h00fe);
        rd(DIG_CFG_ADDR, 16'h0a00);
        rd(TX_CTL_ADDR, 16'h1c00);
        check(16'({drv, lowp, rise}), 16'h000f);
        wr(DIG_CFG_ADDR, 16'h0000);
        wr(TX_CTL_ADDR, 16'h0400);
        tick(1);
        check(16'({drv, lowp, rise}), 16'h0001);
    endtask : t_regs
    task automatic t_static();
        logic [3:0] c[7] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'h6, 4'hf};
        logic e[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        m.lvl(3'h3);
        for (int i = 0; i < 7; i++) begin
            wr(LED_CFG_ADDR, cfg(c[i], 2'h0, 1'b1));
            tick(3);
            check(16'(led), 16'(e[i]));
        end
        m.lvl(3'h4);
        wr(LED_CFG_ADDR, cfg(4'h0, 2'h0, 1'b1));
        tick(3);
        check(16'(led), 16'h0001);
    endtask : t_static
    task automatic t_stretch();
        int len[4] = '{S30, S60, S100, S30};
        logic [3:0] cd[3] = '{4'h1, 4'h3, 4'h7};
        int bt[3] = '{2, 0, 2};
        for (int p = 0; p < 4; p++) begin
            wr(LED_CFG_ADDR, cfg(4'h2, 2'(p), 1'b1));
            cnt(1, len[p] - 1, len[p] + 2);
        end
        for (int i = 0; i < 3; i++) begin
            wr(LED_CFG_ADDR, cfg(cd[i], 2'h0, 1'b1));
            cnt(bt[i], S30 - 1, S30 + 2);
        end
        wr(LED_CFG_ADDR, cfg(4'h1, 2'h0, 1'b0));
        cnt(2, 1, 1);
    endtask : t_stretch
    task automatic t_blink();
        int n;
        logic prev;
        for (int i = 0; i < 2; i++) begin
            wr(LED_CFG_ADDR, cfg(4'(4'ha + i), 2'h0, 1'b1));
            n = 0;
            prev = led;
            repeat (64) begin
                @(negedge clk);
                if (led !== prev) n++;
                prev = led;
            end
            check(16'(i ? (n >= 3 && n <= 5) : (n >= 14 && n <= 18)),
                16'h0001);
        end
    endtask : t_blink
    task automatic t_comb();
        m.lvl(3'h2);
        wr(LED_CFG_ADDR, cfg(4'hc, 2'h0, 1'b0));
        tick(3);
        check(16'(led), 16'h0001);
        m.evt(1);
        tick(5);
        check(16'(led), 16'h0000);
        m.evt(1);
        tick(S30 + 10);
        check(16'(led), 16'h0001);
        m.evt(1);
        tick(5);
        check(16'(led), 16'h0000);
        tick(S30 + 10);
        check(16'(led), 16'h0001);
        wr(LED_CFG_ADDR, cfg(4'h2, 2'h0, 1'b1));
        m.lvl(3'h0);
        wr(LED_CFG_ADDR, cfg(4'hd, 2'h0, 1'b1));
        tick(3);
        check(16'(led), 16'h0000);
        m.evt(2);
        tick(5);
        check(16'(led), 16'h0001);
        tick(S30 + 10);
        check(16'(led), 16'h0000);
        wr(LED_CFG_ADDR, cfg(4'h2, 2'h0, 1'b1));
        m.lvl(3'h1);
        wr(LED_CFG_ADDR, cfg(4'he, 2'h0, 1'b1));
        tick(3);
        check(16'(led), 16'h0001);
        m.evt(0);
        tick(5);
        check(16'(led), 16'h0000);
        tick(S30 + 10);
        check(16'(led), 16'h0001);
    endtask : t_comb
    task automatic t_rxer();
        m.err(1'b1, 1'b0);
        tick(3);
        check(16'(rxer), 16'h0001);
        m.err(1'b0, 1'b1);
        tick(3);
        check(16'(rxer), 16'h0000);
        wr(DIG_CFG_ADDR, 16'h0200);
        tick(3);
        check(16'(rxer), 16'h0001);
        m.err(1'b1, 1'b0);
        tick(3);
        check(16'(rxer), 16'h0000);
    endtask : t_rxer
    task automatic t_strap();
        m.strap(2'h1);
        @(negedge clk);
        rst_n = 1'b0;
        tick(8);
        rst_n = 1'b1;
        tick(2);
        rd(TX_CTL_ADDR, 16'h0400);
        wr(TX_CTL_ADDR, 16'h0c00);
        m.strap(2'h2);
        tick(6);
        check(16'(rise), 16'h0003);
    endtask : t_strap
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        tick(8);
        rst_n = 1'b1;
        tick(2);
        t_regs();
        t_static();
        t_stretch();
        t_blink();
        t_comb();
        t_rxer();
        t_strap();
        conclude();
    end
    initial begin
        #(50 * 20000);
        fail_count++;
        conclude();
    end
endmodule : phy_led_and_vendor_config_regs_bench
